/* File: include/edmac_pkg.sv */
// edmac_pkg: constants and types for the eight channel dma controller
// Contract
// - eight identical channels, each with its own control and status registers
// - a channel moves data ram to peripheral or peripheral to ram
// - transfers use a dedicated bus, never stalling the cpu side
// - register indirect mode with ram address increment after each transfer
// - register indirect mode with a fixed ram address
// - peripheral indirect mode: the peripheral supplies the ram address
// - interrupt at block end, or at half block when selected
// - byte or word per transfer, selectable per channel
// - simultaneous requests resolved by fixed channel priority
// - transfer starts by software force or by selected peripheral request
// - one-shot stops after a block, auto-repeat restarts the block
// - ping-pong alternates primary and secondary start addresses per block
// - seven bit request source select picks the triggering interrupt source
// - peripheral address holds the source data register for peripheral to ram
// - peripheral address holds the destination register for ram to peripheral
// - both directions usable on peripherals supporting them under one request code
// - transfers per block equal transfer count field plus one
// - force bit is cleared only by hardware after the forced transfer

// ********************************************************************
// package
// ********************************************************************
package edmac_pkg;
   localparam int NUM_CH = 8;
   localparam int CH_W   = 3;
   localparam int IRQ_N  = 128;
   localparam int SEL_W  = 7;
   localparam int CNT_W  = 10;
   localparam int AW     = 16;
   localparam int DW     = 16;
   localparam int WB_AW  = 9;
   localparam int WB_DW  = 32;

   // register map: channel block of 32 bytes, status word above
   localparam logic [2:0]       IDX_CON    = 3'h0;
   localparam logic [2:0]       IDX_REQ    = 3'h1;
   localparam logic [2:0]       IDX_STA    = 3'h2;
   localparam logic [2:0]       IDX_STB    = 3'h3;
   localparam logic [2:0]       IDX_PAD    = 3'h4;
   localparam logic [2:0]       IDX_CNT    = 3'h5;
   localparam logic [WB_AW-1:0] STATUS_ADR = 9'h100;

   // control word fields
   localparam int CON_EN    = 15;
   localparam int CON_SIZE  = 14;
   localparam int CON_DIR   = 13;
   localparam int CON_HALF  = 12;
   localparam int CON_NULLW = 11;
   localparam int CON_AMODE = 4;
   localparam int CON_MODE  = 0;
   localparam int REQ_FORCE = 15;
   localparam int MODE_ONE  = 0;
   localparam int MODE_PP   = 1;

   localparam logic [1:0]    AMODE_INC = 2'h0;
   localparam logic [1:0]    AMODE_FIX = 2'h1;
   localparam logic [1:0]    AMODE_PER = 2'h2;
   localparam logic [AW-1:0] STEP_BYTE = 16'h0001;
   localparam logic [AW-1:0] STEP_WORD = 16'h0002;
   localparam logic [DW-1:0] RST_WORD  = 16'h0000;

   // request codes and peripheral register addresses
   localparam logic [SEL_W-1:0] SRC_EXT_INT0   = 7'h00;
   localparam logic [SEL_W-1:0] SRC_CAPTURE1   = 7'h01;
   localparam logic [SEL_W-1:0] SRC_COMPARE1   = 7'h02;
   localparam logic [SEL_W-1:0] SRC_SERIAL1_RX = 7'h0B;
   localparam logic [AW-1:0] CAPTURE1_BUFFER      = 16'h0140;
   localparam logic [AW-1:0] SERIAL1_RECEIVE_REG  = 16'h0226;
   localparam logic [AW-1:0] CONVERTER1_RESULT    = 16'h0300;
   localparam logic [AW-1:0] COMPARE1_MAIN_REG    = 16'h0182;
   localparam logic [AW-1:0] COMPARE1_SECOND_REG  = 16'h0180;
   localparam logic [AW-1:0] SERIAL1_TRANSMIT_REG = 16'h0224;
   localparam logic [AW-1:0] SERIAL_PERIPH1_BUF   = 16'h0248;
   localparam logic [AW-1:0] PARALLEL_PORT_DATA   = 16'h0608;

   // transfer sequencer, gray along idle-read-write-finish
   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_READ   = 2'h1,
      ST_WRITE  = 2'h3,
      ST_FINISH = 2'h2
   } edmac_state_type;
endpackage

/* File: logic/edmac_arbiter.sv */
// edmac_arbiter: fixed priority pick of the lowest requesting channel
`timescale 1ns/10ps
`default_nettype none
module edmac_arbiter
   import edmac_pkg::*;
(
   // channel requests
   input  wire logic [NUM_CH-1:0] req,
   // winner
   output logic                   grant_valid,
   output logic [CH_W-1:0]        grant_idx
);
   // scan downward so the lowest index is the last to win
   always_comb
   begin
      grant_valid = 1'b0;
      grant_idx   = '0;
      for (int k = NUM_CH - 1; k >= 0; k--)
      begin
         if (req[k])
         begin
            grant_valid = 1'b1;
            grant_idx   = CH_W'(k);
         end
      end
   end
endmodule
`default_nettype wire

/* File: logic/edmac_top.sv */
// edmac_top: eight channel dma controller with a wishbone register slave
`timescale 1ns/10ps
`default_nettype none
module edmac_top
   import edmac_pkg::*;
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // wishbone register slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [WB_AW-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [WB_DW-1:0] wb_dat_i,
   output logic      [WB_DW-1:0] wb_dat_o,
   output logic                  wb_ack_o,
   // peripheral requests
   input  wire logic [IRQ_N-1:0] periph_irq,
   input  wire logic [AW-1:0]    periph_ind_addr,
   // dedicated peripheral transfer bus
   output logic                  pbus_rd,
   output logic                  pbus_wr,
   output logic      [AW-1:0]    pbus_addr,
   output logic                  pbus_byte,
   output logic      [DW-1:0]    pbus_wdata,
   input  wire logic [DW-1:0]    pbus_rdata,
   // dual port buffer ram port
   output logic                  ram_rd,
   output logic                  ram_wr,
   output logic      [AW-1:0]    ram_addr,
   output logic                  ram_byte,
   output logic      [DW-1:0]    ram_wdata,
   input  wire logic [DW-1:0]    ram_rdata,
   // block interrupt pulses
   output logic      [NUM_CH-1:0] dma_irq
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic             en_reg    [NUM_CH];
   logic             size_reg  [NUM_CH];
   logic             dir_reg   [NUM_CH];
   logic             half_reg  [NUM_CH];
   logic             nullw_reg [NUM_CH];
   logic             force_reg [NUM_CH];
   logic             pend_reg  [NUM_CH];
   logic             pp_reg    [NUM_CH];
   logic [1:0]       amode_reg [NUM_CH];
   logic [1:0]       mode_reg  [NUM_CH];
   logic [SEL_W-1:0] sel_reg   [NUM_CH];
   logic [AW-1:0]    sta_reg   [NUM_CH];
   logic [AW-1:0]    stb_reg   [NUM_CH];
   logic [AW-1:0]    pad_reg   [NUM_CH];
   logic [AW-1:0]    addr_reg  [NUM_CH];
   logic [CNT_W-1:0] cnt_reg   [NUM_CH];
   logic [CNT_W-1:0] done_reg  [NUM_CH];
   logic [DW-1:0]    con_w     [NUM_CH];

   wire logic [NUM_CH-1:0] ch_req;
   wire logic [NUM_CH-1:0] irq_hit;
   wire logic [NUM_CH-1:0] pp_vec;
   edmac_state_type        state_reg;
   logic [CH_W-1:0]        cur_reg;
   logic                   cur_force_reg;
   logic                   gnt_v;
   logic [CH_W-1:0]        gnt_idx;
   logic                   wb_go;
   logic                   wb_wr;
   logic                   wb_chsp;
   logic [CH_W-1:0]        wb_ch;
   logic [2:0]             wb_idx;
   logic [WB_DW-1:0]       rd_next;

   // merge a write into a 16-bit register honouring byte lanes
   function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0]    old_v,
                                                 input logic [WB_DW-1:0] new_v,
                                                 input logic [3:0]       lanes);
      lane_merge = old_v;
      if (lanes[0])
         lane_merge[7:0] = new_v[7:0];
      if (lanes[1])
         lane_merge[15:8] = new_v[15:8];
   endfunction

   // ****************************************************************
   // wishbone slave
   // ****************************************************************
   // one request per cycle; ack high in the same cycle blocks repeats
   assign wb_go   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr   = wb_go && wb_we_i;
   assign wb_chsp = !wb_adr_i[8];
   assign wb_ch   = wb_adr_i[7:5];
   assign wb_idx  = wb_adr_i[4:2];

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk)
   begin
      if (!resetn)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_go;
   end

   // read decode; unmapped addresses read zero
   always_comb
   begin
      rd_next = '0;
      if (wb_adr_i == STATUS_ADR)
      begin
         rd_next[NUM_CH-1:0]     = pp_vec;
         rd_next[10:8]           = cur_reg;
         rd_next[11]             = (state_reg != ST_IDLE);
      end
      else if (wb_chsp && wb_idx == IDX_CON)
         rd_next[DW-1:0] = con_w[wb_ch];
      else if (wb_chsp && wb_idx == IDX_REQ)
      begin
         rd_next[REQ_FORCE]   = force_reg[wb_ch];
         rd_next[SEL_W-1:0]   = sel_reg[wb_ch];
      end
      else if (wb_chsp && (wb_idx == IDX_STA || wb_idx == IDX_STB))
         rd_next[AW-1:0] = addr_reg[wb_ch]; // live pointer, not the start
      else if (wb_chsp && wb_idx == IDX_PAD)
         rd_next[AW-1:0] = pad_reg[wb_ch];
      else if (wb_chsp && wb_idx == IDX_CNT)
         rd_next[CNT_W-1:0] = cnt_reg[wb_ch];
   end

   // read data held until the next access
   always_ff @(posedge clk)
   begin
      if (!resetn)
         wb_dat_o <= '0;
      else if (wb_go)
         wb_dat_o <= rd_next;
   end

   // ****************************************************************
   // channels
   // ****************************************************************
   for (genvar i = 0; i < NUM_CH; i++)
   begin : g_ch
      logic            hit;
      logic            fin;
      logic            last;
      logic            half_pt;
      logic            trig;
      logic            won;
      logic [DW-1:0]   cw;

      assign con_w[i]   = {en_reg[i], size_reg[i], dir_reg[i], half_reg[i], nullw_reg[i],
                           5'h00, amode_reg[i], 2'h0, mode_reg[i]};
      assign hit        = wb_wr && wb_chsp && wb_ch == CH_W'(i);
      assign cw         = lane_merge(con_w[i], wb_dat_i, wb_sel_i);
      assign fin        = state_reg == ST_FINISH && cur_reg == CH_W'(i);
      assign last       = done_reg[i] == cnt_reg[i];
      assign half_pt    = done_reg[i] == (cnt_reg[i] >> 1);
      assign won        = state_reg == ST_IDLE && gnt_v && gnt_idx == CH_W'(i);
      assign trig       = en_reg[i] && periph_irq[sel_reg[i]];
      assign ch_req[i]  = en_reg[i] && (pend_reg[i] || force_reg[i]);
      assign irq_hit[i] = fin && (half_reg[i] ? half_pt : last);
      assign pp_vec[i]  = pp_reg[i];

      // software configuration, one private set per channel
      always_ff @(posedge clk)
      begin
         if (!resetn)
         begin
            size_reg[i]  <= 1'b0;
            dir_reg[i]   <= 1'b0;
            half_reg[i]  <= 1'b0;
            nullw_reg[i] <= 1'b0;
            amode_reg[i] <= AMODE_INC;
            mode_reg[i]  <= 2'h0;
            sel_reg[i]   <= '0;
            sta_reg[i]   <= RST_WORD;
            stb_reg[i]   <= RST_WORD;
            pad_reg[i]   <= RST_WORD;
            cnt_reg[i]   <= '0;
         end
         else if (hit)
         begin
            if (wb_idx == IDX_CON)
            begin
               size_reg[i]  <= cw[CON_SIZE];
               dir_reg[i]   <= cw[CON_DIR];
               half_reg[i]  <= cw[CON_HALF];
               nullw_reg[i] <= cw[CON_NULLW];
               amode_reg[i] <= cw[CON_AMODE+1:CON_AMODE];
               mode_reg[i]  <= cw[CON_MODE+1:CON_MODE];
            end
            else if (wb_idx == IDX_REQ && wb_sel_i[0])
               sel_reg[i] <= wb_dat_i[SEL_W-1:0];
            else if (wb_idx == IDX_STA)
               sta_reg[i] <= lane_merge(sta_reg[i], wb_dat_i, wb_sel_i);
            else if (wb_idx == IDX_STB)
               stb_reg[i] <= lane_merge(stb_reg[i], wb_dat_i, wb_sel_i);
            else if (wb_idx == IDX_PAD)
               pad_reg[i] <= lane_merge(pad_reg[i], wb_dat_i, wb_sel_i);
            else if (wb_idx == IDX_CNT)
               cnt_reg[i] <= CNT_W'(lane_merge({6'h00, cnt_reg[i]}, wb_dat_i, wb_sel_i));
         end
      end

      // pending request and force; a new event beats the clear
      always_ff @(posedge clk)
      begin
         if (!resetn)
         begin
            pend_reg[i]  <= 1'b0;
            force_reg[i] <= 1'b0;
         end
         else
         begin
            pend_reg[i] <= en_reg[i] && (trig || (pend_reg[i] && !(won && !force_reg[i])));
            if (hit && wb_idx == IDX_REQ && wb_sel_i[1] && wb_dat_i[REQ_FORCE])
               force_reg[i] <= 1'b1;
            else if (fin && cur_force_reg)
               force_reg[i] <= 1'b0;
         end
      end

      // enable, buffer pointer and block progress
      always_ff @(posedge clk)
      begin
         if (!resetn)
         begin
            en_reg[i]   <= 1'b0;
            addr_reg[i] <= RST_WORD;
            done_reg[i] <= '0;
            pp_reg[i]   <= 1'b0;
         end
         else
         begin
            if (fin && last)
            begin
               done_reg[i] <= '0;
               if (mode_reg[i][MODE_PP])
               begin
                  pp_reg[i]   <= !pp_reg[i];
                  addr_reg[i] <= pp_reg[i] ? sta_reg[i] : stb_reg[i];
               end
               else
                  addr_reg[i] <= sta_reg[i];
               // one-shot ping-pong stops after the secondary block
               if (mode_reg[i][MODE_ONE] && (!mode_reg[i][MODE_PP] || pp_reg[i]))
                  en_reg[i] <= 1'b0;
            end
            else if (fin)
            begin
               done_reg[i] <= done_reg[i] + 1'b1;
               if (amode_reg[i] == AMODE_INC)
                  addr_reg[i] <= addr_reg[i] + (size_reg[i] ? STEP_BYTE : STEP_WORD);
            end
            // software enable restarts the block at the primary buffer
            if (hit && wb_idx == IDX_CON && wb_sel_i[1])
            begin
               en_reg[i] <= cw[CON_EN];
               if (!en_reg[i] && cw[CON_EN])
               begin
                  addr_reg[i] <= sta_reg[i];
                  done_reg[i] <= '0;
                  pp_reg[i]   <= 1'b0;
               end
            end
         end
      end
   end

   // ****************************************************************
   // transfer sequencer
   // ****************************************************************
   edmac_arbiter u_arb (
      .req         (ch_req),
      .grant_valid (gnt_v),
      .grant_idx   (gnt_idx)
   );

   // read source, then write destination; cpu bus never waits on it
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_reg     <= ST_IDLE;
         cur_reg       <= '0;
         cur_force_reg <= 1'b0;
         pbus_rd       <= 1'b0;
         pbus_wr       <= 1'b0;
         pbus_addr     <= RST_WORD;
         pbus_byte     <= 1'b0;
         pbus_wdata    <= RST_WORD;
         ram_rd        <= 1'b0;
         ram_wr        <= 1'b0;
         ram_addr      <= RST_WORD;
         ram_byte      <= 1'b0;
         ram_wdata     <= RST_WORD;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
               if (gnt_v)
               begin
                  cur_reg       <= gnt_idx;
                  cur_force_reg <= force_reg[gnt_idx];
                  pbus_addr     <= pad_reg[gnt_idx];
                  pbus_byte     <= size_reg[gnt_idx];
                  ram_byte      <= size_reg[gnt_idx];
                  if (amode_reg[gnt_idx] == AMODE_PER)
                     ram_addr <= periph_ind_addr;
                  else
                     ram_addr <= addr_reg[gnt_idx];
                  if (dir_reg[gnt_idx])
                     ram_rd <= 1'b1;
                  else
                     pbus_rd <= 1'b1;
                  state_reg <= ST_READ;
               end
            ST_READ:
            begin
               pbus_rd   <= 1'b0;
               ram_rd    <= 1'b0;
               state_reg <= ST_WRITE;
            end
            ST_WRITE:
            begin
               if (dir_reg[cur_reg])
               begin
                  pbus_wr    <= 1'b1;
                  pbus_wdata <= ram_byte ? {8'h00, ram_rdata[7:0]} : ram_rdata;
               end
               else
               begin
                  ram_wr    <= 1'b1;
                  ram_wdata <= pbus_byte ? {8'h00, pbus_rdata[7:0]} : pbus_rdata;
                  // null write: zero back to the peripheral alongside
                  if (nullw_reg[cur_reg])
                  begin
                     pbus_wr    <= 1'b1;
                     pbus_wdata <= RST_WORD;
                  end
               end
               state_reg <= ST_FINISH;
            end
            ST_FINISH:
            begin
               pbus_wr   <= 1'b0;
               ram_wr    <= 1'b0;
               state_reg <= ST_IDLE;
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // block interrupt pulses to the interrupt controller
   always_ff @(posedge clk)
   begin
      if (!resetn)
         dma_irq <= '0;
      else
         dma_irq <= irq_hit;
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("wishbone ack held longer than one cycle");
   chk_seq_length: assert property ($rose(pbus_rd) || $rose(ram_rd) |=>
      state_reg == ST_WRITE ##1 state_reg == ST_FINISH ##1 state_reg == ST_IDLE)
      else $error("transfer sequence not four cycles");
   chk_periph_to_ram: assert property ($rose(pbus_rd) && !dir_reg[cur_reg] |-> ##2 ram_wr)
      else $error("peripheral read not followed by ram write");
   chk_ram_to_periph: assert property ($rose(ram_rd) |-> ##2 (pbus_wr && !ram_wr))
      else $error("ram read not followed by peripheral write");
   chk_lowest_wins: assert property (state_reg == ST_IDLE && gnt_v |=>
      ($past(ch_req) & ((8'h01 << cur_reg) - 8'h01)) == 8'h00)
      else $error("lower channel was passed over");
   chk_post_inc: assert property (state_reg == ST_FINISH && amode_reg[cur_reg] == AMODE_INC
      && done_reg[cur_reg] != cnt_reg[cur_reg] && !wb_wr |=>
      addr_reg[$past(cur_reg)] == $past(ram_addr) + ($past(ram_byte) ? STEP_BYTE : STEP_WORD))
      else $error("pointer did not advance by the transfer size");
   chk_fixed_addr: assert property (state_reg == ST_FINISH && amode_reg[cur_reg] == AMODE_FIX
      && done_reg[cur_reg] != cnt_reg[cur_reg] && !wb_wr |=>
      addr_reg[$past(cur_reg)] == $past(addr_reg[cur_reg]))
      else $error("fixed pointer moved");
   chk_periph_addr: assert property (state_reg == ST_IDLE && gnt_v && amode_reg[gnt_idx] == AMODE_PER
      |=> ram_addr == $past(periph_ind_addr))
      else $error("peripheral supplied address not used");
   chk_one_shot: assert property (state_reg == ST_FINISH && done_reg[cur_reg] == cnt_reg[cur_reg]
      && mode_reg[cur_reg] == 2'h1 && !wb_wr |=> !en_reg[$past(cur_reg)])
      else $error("one-shot channel still enabled after its block");
   chk_force_clear: assert property (state_reg == ST_FINISH && cur_force_reg && !wb_wr
      |=> !force_reg[$past(cur_reg)])
      else $error("force bit not cleared after forced transfer");
   chk_full_irq: assert property (state_reg == ST_FINISH && !half_reg[cur_reg]
      && done_reg[cur_reg] == cnt_reg[cur_reg] |=> dma_irq[$past(cur_reg)])
      else $error("block end interrupt missing");

   cov_ping_pong: cover property (state_reg == ST_FINISH && mode_reg[cur_reg][MODE_PP]
      && done_reg[cur_reg] == cnt_reg[cur_reg]);
   cov_forced: cover property (state_reg == ST_FINISH && cur_force_reg);
   cov_half_irq: cover property (state_reg == ST_FINISH && half_reg[cur_reg] && dma_irq == 8'h00
      ##1 dma_irq != 8'h00);
   cov_contend: cover property (state_reg == ST_IDLE && $countones(ch_req) > 1);
endmodule
`default_nettype wire

/* File: tb/edmac_periph_model.sv */
// edmac_periph_model: peripheral registers and buffer ram answering the dma buses
`timescale 1ns/10ps
`default_nettype none
module edmac_periph_model
   import edmac_pkg::*;
(
   // clock
   input  wire logic          clk,
   // peripheral side
   input  wire logic          pbus_rd,
   input  wire logic [AW-1:0] pbus_addr,
   output logic      [DW-1:0] pbus_rdata,
   // buffer ram side
   input  wire logic          ram_rd,
   input  wire logic [AW-1:0] ram_addr,
   output logic      [DW-1:0] ram_rdata
);
   // data valid one cycle after a strobe, churning otherwise so stale reads show
   always @(posedge clk)
   begin
      pbus_rdata <= pbus_rd ? (pbus_addr ^ 16'h5A5A) : ~pbus_rdata;
      ram_rdata  <= ram_rd ? (ram_addr ^ 16'hC3C3) : ~ram_rdata;
   end
endmodule
`default_nettype wire

/* File: tb/eight_channel_dma_controller_bench.sv */
// eight_channel_dma_controller_bench: directed scenarios for the dma controller
`timescale 1ns/10ps
`default_nettype none
module eight_channel_dma_controller_bench
   import edmac_pkg::*;
;
   logic clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, ack, prd, pwr, pby, rrd, rwr, rby;
   logic [WB_AW-1:0] adr = '0;
   logic [3:0] sel = '0;
   logic [WB_DW-1:0] dat = '0, wdo;
   logic [IRQ_N-1:0] irq = '0;
   logic [AW-1:0] ind = 16'h0A40, pa, ra_o;
   logic [DW-1:0] pwd, prdat, rwd, rrdat;
   logic [NUM_CH-1:0] dirq;
   int miscompares = 0, compares = 0;
   always #20 clk = ~clk;
   edmac_top dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
      .periph_irq(irq), .periph_ind_addr(ind), .pbus_rd(prd), .pbus_wr(pwr), .pbus_addr(pa),
      .pbus_byte(pby), .pbus_wdata(pwd), .pbus_rdata(prdat), .ram_rd(rrd), .ram_wr(rwr),
      .ram_addr(ra_o), .ram_byte(rby), .ram_wdata(rwd), .ram_rdata(rrdat), .dma_irq(dirq));
   edmac_periph_model far (.clk(clk), .pbus_rd(prd), .pbus_addr(pa), .pbus_rdata(prdat),
      .ram_rd(rrd), .ram_addr(ra_o), .ram_rdata(rrdat));
   // ********************************************************************
   // shared tasks
   // ********************************************************************
   task automatic report_and_stop;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [WB_AW-1:0] ra(input int ch, input logic [2:0] idx);
      return WB_AW'(ch * 32 + idx * 4);
   endfunction
   // classic single cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [WB_AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'h3;
      n = 0;
      do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin miscompares++; report_and_stop(); end
      q = wdo;
      cyc <= 0; stb <= 0; we <= 0;
   endtask
   task automatic pulse(input logic [SEL_W-1:0] s);
      @(posedge clk) irq[s] <= 1'b1;
      @(posedge clk) irq[s] <= 1'b0;
   endtask
   // wait for a write strobe on the peripheral (p=1) or ram bus, bounded
   task automatic waitw(input logic p);
      int n;
      n = 0;
      do begin @(posedge clk); n++; end while ((p ? pwr : rwr) !== 1'b1 && n < 40);
      if (n >= 40) begin miscompares++; report_and_stop(); end
   endtask
   // ********************************************************************
   // scenarios
   // ********************************************************************
   task automatic s_regs;
      logic [31:0] q;
      wb(0, ra(0, IDX_CON), 0, q); chk(q, 0);
      wb(1, ra(7, IDX_PAD), 32'h1234, q); wb(0, ra(7, IDX_PAD), 0, q); chk(q, 32'h1234);
      wb(0, 9'h1FC, 0, q); chk(q, 0);
   endtask
   // peripheral to ram, post increment, one shot, three transfers
   task automatic s_inc;
      logic [31:0] q;
      int n;
      wb(1, ra(0, IDX_STA), 32'h0800, q); wb(1, ra(0, IDX_PAD), 32'(SERIAL1_RECEIVE_REG), q);
      wb(1, ra(0, IDX_CNT), 2, q); wb(1, ra(0, IDX_REQ), 32'(SRC_SERIAL1_RX), q);
      wb(1, ra(0, IDX_CON), 32'h8001, q);
      for (int i = 0; i < 3; i++)
      begin
         pulse(SRC_SERIAL1_RX); repeat (2) @(posedge clk); chk(prd, 1);
         waitw(0);
         chk(ra_o, 32'h0800 + 2 * i);
         chk(rwd, SERIAL1_RECEIVE_REG ^ 16'h5A5A);
         @(posedge clk); chk(dirq, (i == 2) ? 1 : 0);
      end
      wb(0, ra(0, IDX_CON), 0, q); chk(q[15], 0);
      pulse(SRC_SERIAL1_RX);
      n = 0;
      repeat (10) begin @(posedge clk); if (rwr === 1'b1) n++; end
      chk(n, 0);
   endtask
   // ram to peripheral, fixed address, byte size, software forced
   task automatic s_force;
      logic [31:0] q;
      wb(1, ra(1, IDX_STA), 32'h0900, q); wb(1, ra(1, IDX_PAD), 32'(COMPARE1_MAIN_REG), q);
      wb(1, ra(1, IDX_CNT), 1, q); wb(1, ra(1, IDX_CON), 32'hE010, q);
      for (int k = 0; k < 2; k++)
      begin
         wb(1, ra(1, IDX_REQ), 32'h8000, q);
         @(posedge clk); chk(rrd, 1);
         waitw(1);
         chk(pa, COMPARE1_MAIN_REG);
         chk(pwd, 16'h00C3);
         chk(ra_o, 16'h0900);
         @(posedge clk); chk(dirq, (k == 1) ? 2 : 0);
         wb(0, ra(1, IDX_REQ), 0, q); chk(q[15], 0);
      end
   endtask
   // two channels on one source: lower channel first, indirect address
   task automatic s_prio;
      logic [31:0] q;
      for (int c = 2; c < 4; c++)
      begin
         wb(1, ra(c, IDX_REQ), 32'(SRC_CAPTURE1), q); wb(1, ra(c, IDX_STA), 32'h0A00, q);
      end
      wb(1, ra(3, IDX_CON), 32'h8000, q); wb(1, ra(2, IDX_CON), 32'h8020, q);
      pulse(SRC_CAPTURE1);
      waitw(0); chk(ra_o, ind);
      waitw(0); chk(ra_o, 16'h0A00);
   endtask
   // byte, null write, half irq, continuous ping-pong over two blocks
   task automatic s_ping;
      logic [31:0] q;
      wb(1, ra(4, IDX_STA), 32'h0B00, q); wb(1, ra(4, IDX_STB), 32'h0C00, q);
      wb(1, ra(4, IDX_PAD), 32'(SERIAL_PERIPH1_BUF), q); wb(1, ra(4, IDX_CNT), 1, q);
      wb(1, ra(4, IDX_REQ), 32'(SRC_COMPARE1), q); wb(1, ra(4, IDX_CON), 32'hD802, q);
      for (int j = 0; j < 4; j++)
      begin
         pulse(SRC_COMPARE1); waitw(0);
         chk(ra_o, ((j < 2) ? 32'h0B00 : 32'h0C00) + j % 2);
         chk(rwd, 16'h0012);
         chk({pby, rby, pwr}, 3'h7);
         chk(pwd, 0);
         chk(pa, SERIAL_PERIPH1_BUF);
         @(posedge clk); chk(dirq, (j % 2 == 0) ? 32'h10 : 0);
         if (j == 1)
         begin
            wb(0, STATUS_ADR, 0, q); chk(q[11:0], 12'h410);
         end
      end
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      s_regs();
      s_inc();
      s_force();
      s_prio();
      s_ping();
      report_and_stop();
   end
endmodule
`default_nettype wire
